// [hdl/fswd_pkg.sv]
// Constants, register map and types of the fail-safe watchdog unit
package fswd_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADR_IE0 = 8'h00;
   localparam logic [7:0] ADR_IE1 = 8'h04;
   localparam logic [7:0] ADR_IP0 = 8'h08;
   localparam logic [7:0] ADR_PERIOD = 8'h0c;
   localparam logic [7:0] ADR_COUNT = 8'h10;
   localparam logic [7:0] ADR_OSC = 8'h14;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h18;
   localparam logic [7:0] ADR_IRQ_CLR = 8'h1c;
   localparam logic [7:0] ADR_IRQ_EN = 8'h20;
   // ****************************************
   // Fields
   // ****************************************
   localparam int REFRESH_BIT = 0;
   localparam int START_BIT = 0;
   localparam int FLAG_BIT = 0;
   localparam int PERIOD_W = 11;
   localparam logic [PERIOD_W-1:0] PERIOD_RST = 11'h7ff;
   localparam int IRQ_W = 3;
   localparam int IRQ_EXPIRE = 0;
   localparam int IRQ_OSC_FAIL = 1;
   localparam int IRQ_OSC_OK = 2;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int WD_TICK_NS = 512000;
   localparam int WD_TICK_CYC = WD_TICK_NS / CLK_PERIOD_NS;
   localparam int OSC_EXT_NS = 250000;
   localparam int OSC_EXT_CYC = OSC_EXT_NS / CLK_PERIOD_NS;
   localparam int POR_MAX_NS = 34000;
   localparam int POR_MAX_CYC = POR_MAX_NS / CLK_PERIOD_NS;
   localparam int OSC_WIN = 16;
   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } fswd_req_t;
   typedef enum logic [1:0] {
      OSC_FAIL = 2'b00,
      OSC_EXTEND = 2'b01,
      OSC_RUN = 2'b10
   } fswd_osc_t;
endpackage

// [hdl/fswd_top.sv]
// Fail-safe unit: software watchdog plus oscillator monitor
//
// Functional notes
// - Strap pin high at reset starts watchdog
// - Strap pin is sampled only at reset
// - Writing start bit starts the watchdog
// - Refresh needs refresh bit then start bit
// - Expiry keeps counting and sets status flag
// - Software may clear the status flag
// - Slow main clock: RC clock, hold reset
// - Recovery extends reset by 0.25 ms
// - Power-down exit handled like a failure
// - After power-on run from RC clock
// - Ports held in reset state meanwhile
// - Reset state reached within 34 us
// - Time-out programmable, 512 us steps
`timescale 1ns/10ps
`default_nettype none
module fswd_top #(
   parameter int WD_TICK = fswd_pkg::WD_TICK_CYC,
   parameter int EXT_CYC = fswd_pkg::OSC_EXT_CYC,
   parameter int WIN = fswd_pkg::OSC_WIN
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire fswd_pkg::fswd_req_t req,
   output logic [31:0] rdata,
   input wire logic hw_watchdog_enable_pin,
   input wire logic main_osc_in,
   input wire logic rc_osc_in,
   input wire logic hw_pd_exit,
   output logic wd_reset_req,
   output logic osc_reset_hold,
   output logic clk_sel_rc,
   output logic port_reset,
   output logic irq
);
   import fswd_pkg::*;

   if (WD_TICK < 2 || EXT_CYC < 2 || WIN < 2 || WIN > 255) begin : g_chk
      $error("fswd_top: unsupported parameter value");
   end

   localparam int PW = $clog2(WD_TICK);
   localparam int EW = $clog2(EXT_CYC + 1);

   // ****************************************
   // Reset release and pin synchronisers
   // ****************************************
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   logic [1:0] osc_d3_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Oscillator inputs are sampled as plain levels; edges seen past stage two
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
         osc_d3_q <= 2'h0;
      end else begin
         pin_s1_q <= {hw_pd_exit, rc_osc_in, main_osc_in, hw_watchdog_enable_pin};
         pin_s2_q <= pin_s1_q;
         osc_d3_q <= pin_s2_q[2:1];
      end
   end

   logic main_edge;
   logic rc_edge;
   logic pd_exit_s;
   assign main_edge = pin_s2_q[1] & ~osc_d3_q[0];
   assign rc_edge = pin_s2_q[2] & ~osc_d3_q[1];
   assign pd_exit_s = pin_s2_q[3];

   // ****************************************
   // Bus decode
   // ****************************************
   function automatic logic wr_at(input fswd_req_t r, input logic [7:0] a);
      return r.wr && (r.addr == a);
   endfunction

   logic start_wr;
   logic refresh_wr;
   assign start_wr = wr_at(req, ADR_IE1) && req.wdata[START_BIT];
   assign refresh_wr = wr_at(req, ADR_IE0) && req.wdata[REFRESH_BIT];

   // ****************************************
   // Strap capture
   // ****************************************
   // Strap is taken once the synchroniser has settled after release
   logic [1:0] rel_cnt_q;
   logic strap_take;
   assign strap_take = (rel_cnt_q == 2'h2);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rel_cnt_q <= 2'h0;
      end else if (rel_cnt_q != 2'h3) begin
         rel_cnt_q <= rel_cnt_q + 2'h1;
      end
   end

   // ****************************************
   // Software watchdog
   // ****************************************
   logic wd_run_q;
   logic pend_q;
   logic flag_q;
   logic [PERIOD_W-1:0] period_q;
   logic [PERIOD_W-1:0] cnt_q;
   logic [PW-1:0] pre_q;
   logic tick;
   logic expire;
   logic strap_start;
   logic refresh_ok;
   logic reload;

   assign tick = wd_run_q && (pre_q == PW'(WD_TICK - 1));
   assign expire = tick && (cnt_q == '0);
   assign strap_start = strap_take && pin_s2_q[0];
   assign refresh_ok = start_wr && pend_q && wd_run_q;
   assign reload = refresh_ok || (start_wr && !wd_run_q) || strap_start || expire;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wd_run_q <= 1'b0;
      end else if (strap_start || start_wr) begin
         wd_run_q <= 1'b1;
      end
   end

   // Any other write breaks the two-step sequence
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
      end else if (req.wr) begin
         pend_q <= refresh_wr;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         period_q <= PERIOD_RST;
      end else if (wr_at(req, ADR_PERIOD)) begin
         period_q <= req.wdata[PERIOD_W-1:0];
      end
   end

   // Count of 512 us ticks left; expiry reloads and keeps running
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= '0;
         cnt_q <= PERIOD_RST;
      end else if (reload) begin
         pre_q <= '0;
         cnt_q <= period_q;
      end else if (tick) begin
         pre_q <= '0;
         cnt_q <= cnt_q - 1'b1;
      end else if (wd_run_q) begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // Expiry wins over a clear in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else if (expire) begin
         flag_q <= 1'b1;
      end else if (wr_at(req, ADR_IP0)) begin
         flag_q <= req.wdata[FLAG_BIT];
      end
   end

   // ****************************************
   // Oscillator monitor
   // ****************************************
   logic [7:0] win_q;
   logic [7:0] mcnt_q;
   logic [7:0] mcnt_n;
   logic win_end;
   logic win_ok;
   assign mcnt_n = (main_edge && mcnt_q != 8'(WIN)) ? mcnt_q + 8'h1 : mcnt_q;
   assign win_end = rc_edge && (win_q == 8'(WIN - 1));
   assign win_ok = (mcnt_n >= 8'(WIN));

   // Main edges are counted over a window of RC edges
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         win_q <= '0;
         mcnt_q <= '0;
      end else if (win_end) begin
         win_q <= '0;
         mcnt_q <= '0;
      end else begin
         win_q <= rc_edge ? win_q + 8'h1 : win_q;
         mcnt_q <= mcnt_n;
      end
   end

   fswd_osc_t osc_q;
   fswd_osc_t osc_d;
   logic [EW-1:0] ext_q;

   always_comb begin
      osc_d = osc_q;
      case (osc_q)
         OSC_FAIL: begin
            if (win_end && win_ok) begin
               osc_d = OSC_EXTEND;
            end
         end
         OSC_EXTEND: begin
            if (win_end && !win_ok) begin
               osc_d = OSC_FAIL;
            end else if (ext_q == EW'(EXT_CYC - 1)) begin
               osc_d = OSC_RUN;
            end
         end
         OSC_RUN: begin
            if (win_end && !win_ok) begin
               osc_d = OSC_FAIL;
            end
         end
         default: begin
            osc_d = OSC_FAIL;
         end
      endcase
      if (pd_exit_s) begin
         osc_d = OSC_FAIL;
      end
   end

   // Power-on starts in the failure state, so the RC clock drives reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         osc_q <= OSC_FAIL;
      end else begin
         osc_q <= osc_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ext_q <= '0;
      end else if (osc_q == OSC_EXTEND && osc_d == OSC_EXTEND) begin
         ext_q <= ext_q + 1'b1;
      end else begin
         ext_q <= '0;
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] ist_q;
   logic [IRQ_W-1:0] ien_q;
   logic [IRQ_W-1:0] ist_d;
   always_comb begin
      ev = '0;
      ev[IRQ_EXPIRE] = expire;
      ev[IRQ_OSC_FAIL] = (osc_d == OSC_FAIL) && (osc_q != OSC_FAIL);
      ev[IRQ_OSC_OK] = (osc_d == OSC_RUN) && (osc_q != OSC_RUN);
      ist_d = ist_q;
      if (wr_at(req, ADR_IRQ_CLR)) begin
         ist_d = ist_q & ~req.wdata[IRQ_W-1:0];
      end
      ist_d = ist_d | ev;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ist_q <= '0;
         ien_q <= '0;
      end else begin
         ist_q <= ist_d;
         ien_q <= wr_at(req, ADR_IRQ_EN) ? req.wdata[IRQ_W-1:0] : ien_q;
      end
   end

   // ****************************************
   // Outputs and read data
   // ****************************************
   // Hold, clock-select and port outputs reset active at once, before any clock edge; wd_reset_req and irq reset low
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wd_reset_req <= 1'b0;
         osc_reset_hold <= 1'b1;
         clk_sel_rc <= 1'b1;
         port_reset <= 1'b1;
         irq <= 1'b0;
      end else begin
         wd_reset_req <= expire;
         osc_reset_hold <= (osc_d != OSC_RUN);
         clk_sel_rc <= (osc_d == OSC_FAIL);
         port_reset <= (osc_d != OSC_RUN) || expire;
         irq <= |(ist_d & ien_q);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (req.rd) begin
         case (req.addr)
            ADR_IE0: rdata <= 32'(pend_q);
            ADR_IE1: rdata <= 32'(wd_run_q);
            ADR_IP0: rdata <= 32'(flag_q);
            ADR_PERIOD: rdata <= 32'(period_q);
            ADR_COUNT: rdata <= 32'(cnt_q);
            ADR_OSC: rdata <= 32'({osc_d != OSC_RUN, osc_q});
            ADR_IRQ_STAT: rdata <= 32'(ist_q);
            ADR_IRQ_EN: rdata <= 32'(ien_q);
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_strap_start;
      @(posedge mclk) disable iff (!rst_n)
      strap_take && pin_s2_q[0] |=> wd_run_q && cnt_q == period_q;
   endproperty
   a_strap_start: assert property (p_strap_start) else $error("strap did not start watchdog");

   property p_strap_late;
      @(posedge mclk) disable iff (!rst_n)
      $rose(wd_run_q) |-> $past(start_wr) || $past(strap_take);
   endproperty
   a_strap_late: assert property (p_strap_late) else $error("watchdog started without cause");

   property p_sw_start;
      @(posedge mclk) disable iff (!rst_n)
      start_wr |=> wd_run_q;
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("start bit ignored");

   property p_refresh;
      @(posedge mclk) disable iff (!rst_n)
      wr_at(req, ADR_IE0) && req.wdata[REFRESH_BIT] && wd_run_q ##1 start_wr
      |=> cnt_q == $past(period_q) && pre_q == '0;
   endproperty
   a_refresh: assert property (p_refresh) else $error("refresh pair did not reload");

   property p_expire;
      @(posedge mclk) disable iff (!rst_n)
      expire |=> flag_q && wd_run_q && wd_reset_req && cnt_q == $past(period_q);
   endproperty
   a_expire: assert property (p_expire) else $error("expiry handling wrong");

   property p_clear;
      @(posedge mclk) disable iff (!rst_n)
      wr_at(req, ADR_IP0) && !req.wdata[FLAG_BIT] && !expire |=> !flag_q;
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");

   property p_fail;
      @(posedge mclk) disable iff (!rst_n)
      osc_q == OSC_FAIL |-> clk_sel_rc && osc_reset_hold && port_reset;
   endproperty
   a_fail: assert property (p_fail) else $error("failure not held");

   property p_extend;
      @(posedge mclk) disable iff (!rst_n)
      $fell(osc_reset_hold) |-> $past(ext_q) == EW'(EXT_CYC - 1) && !clk_sel_rc;
   endproperty
   a_extend: assert property (p_extend) else $error("reset released early");

   property p_pd_exit;
      @(posedge mclk) disable iff (!rst_n)
      pd_exit_s |=> osc_q == OSC_FAIL && clk_sel_rc;
   endproperty
   a_pd_exit: assert property (p_pd_exit) else $error("power-down exit not supervised");

   property p_por;
      @(posedge mclk) disable iff (!rst_n)
      rel_cnt_q == 2'h0 |-> port_reset && clk_sel_rc;
   endproperty
   a_por: assert property (p_por) else $error("reset state not reached");

   property p_tick;
      @(posedge mclk) disable iff (!rst_n)
      tick && !reload |=> cnt_q == $past(cnt_q) - 1'b1;
   endproperty
   a_tick: assert property (p_tick) else $error("tick count wrong");

   property p_discard;
      @(posedge mclk) disable iff (!rst_n)
      pend_q && req.wr && !start_wr && !refresh_wr ##1 start_wr && !tick && wd_run_q
      |=> cnt_q == $past(cnt_q);
   endproperty
   a_discard: assert property (p_discard) else $error("stale refresh reloaded");
endmodule // fswd_top
`default_nettype wire

// [tb/fswd_tb.sv]
// Self-checking testbench of the fail-safe watchdog unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
   import fswd_pkg::*;
   localparam int WDT = 8;
   localparam int EXT = 8;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   fswd_req_t req = '0;
   logic [31:0] rdata;
   logic strap = 1'b0;
   logic main_osc_in = 1'b0;
   logic rc_osc_in = 1'b0;
   logic hw_pd_exit = 1'b0;
   logic main_on = 1'b0;
   logic wd_reset_req, osc_reset_hold, clk_sel_rc, port_reset, irq;
   logic [3:0] osc_div = '0;
   int err_count = 0;
   int n_compared = 0;
   always #5 mclk = ~mclk;
   // ****************************************
   // Oscillator stimulus
   // ****************************************
   // Main runs four times faster than the RC reference; stopping it holds the level
   always @(posedge mclk) begin
      osc_div <= osc_div + 4'h1;
      if (osc_div[2:0] == 3'h7) rc_osc_in <= ~rc_osc_in;
      if (main_on && osc_div[0]) main_osc_in <= ~main_osc_in;
   end
   fswd_top #(.WD_TICK(WDT), .EXT_CYC(EXT), .WIN(4)) DUT (
      .mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata),
      .hw_watchdog_enable_pin(strap), .main_osc_in(main_osc_in), .rc_osc_in(rc_osc_in),
      .hw_pd_exit(hw_pd_exit), .wd_reset_req(wd_reset_req), .osc_reset_hold(osc_reset_hold),
      .clk_sel_rc(clk_sel_rc), .port_reset(port_reset), .irq(irq)
   );
   // ****************************************
   // Bus and wait helpers
   // ****************************************
   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge mclk);
      req.wr <= 1'b0;
      #1;
   endtask
   // Back-to-back writes with no idle cycle, as the two-step refresh allows
   task automatic bws(input int k, input logic [7:0] a0, input logic [31:0] d0, input logic [7:0] a1,
                      input logic [31:0] d1, input logic [7:0] a2, input logic [31:0] d2);
      @(posedge mclk);
      for (int i = 0; i < k; i++) begin
         req.addr <= (i == 0) ? a0 : (i == 1) ? a1 : a2;
         req.wdata <= (i == 0) ? d0 : (i == 1) ? d1 : d2;
         req.wr <= 1'b1;
         @(posedge mclk);
      end
      req.wr <= 1'b0;
      #1;
   endtask
   task automatic br(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge mclk);
      req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   function automatic logic pick(input int s);
      return (s == 0) ? clk_sel_rc : (s == 1) ? osc_reset_hold : wd_reset_req;
   endfunction
   task automatic wait_lvl(input int s, input logic v, input int lim, output int n);
      n = 0;
      while (pick(s) !== v && n < lim) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= lim) begin
         err_count++;
         $display("BAD wait %0d exp %h got %h", s, v, pick(s));
      end
   endtask
   task automatic pulse(output int n);
      @(posedge mclk);
      #1;
      wait_lvl(2, 1'b1, 5000, n);
      n = n + 1;
   endtask
   task automatic do_reset(input logic s);
      rst_b <= 1'b0;
      strap <= s;
      repeat (6) @(posedge mclk);
      #1;
      `CHK("rst clk_sel_rc", 1'b1, clk_sel_rc)
      `CHK("rst port_reset", 1'b1, port_reset)
      `CHK("rst hold", 1'b1, osc_reset_hold)
      `CHK("rst wd_req", 1'b0, wd_reset_req)
      @(posedge mclk);
      rst_b <= 1'b1;
      repeat (8) @(posedge mclk);
      strap <= 1'b0;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset_vals;
      logic [31:0] d;
      br(ADR_PERIOD, d);
      `CHK("period rst", 32'h7ff, d)
      br(ADR_IP0, d);
      `CHK("flag rst", 32'h0, d)
      br(ADR_IRQ_EN, d);
      `CHK("irq_en rst", 32'h0, d)
      strap <= 1'b1;
      repeat (10) @(posedge mclk);
      br(ADR_IE1, d);
      `CHK("late strap", 32'h0, d)
      strap <= 1'b0;
      br(8'h30, d);
      `CHK("unmapped rd", 32'h0, d)
   endtask
   task automatic t_osc;
      logic [31:0] d;
      int n;
      br(ADR_OSC, d);
      `CHK("osc fail", 32'h4, d)
      bw(ADR_IRQ_CLR, 32'h7);
      main_on <= 1'b1;
      wait_lvl(0, 1'b0, 400, n);
      `CHK("extend hold", 1'b1, osc_reset_hold)
      wait_lvl(1, 1'b0, 200, n);
      `CHK("extend len", 1'b1, n >= EXT - 1 && n <= EXT + 1)
      `CHK("run ports", 1'b0, port_reset)
      br(ADR_OSC, d);
      `CHK("osc run", 32'h2, d)
      br(ADR_IRQ_STAT, d);
      `CHK("stat ok", 1'b1, d[IRQ_OSC_OK])
      main_on <= 1'b0;
      wait_lvl(0, 1'b1, 400, n);
      `CHK("fail hold", 1'b1, osc_reset_hold)
      `CHK("fail ports", 1'b1, port_reset)
      br(ADR_IRQ_STAT, d);
      `CHK("stat fail", 1'b1, d[IRQ_OSC_FAIL])
      main_on <= 1'b1;
      wait_lvl(1, 1'b0, 600, n);
      hw_pd_exit <= 1'b1;
      wait_lvl(0, 1'b1, 20, n);
      `CHK("pd hold", 1'b1, osc_reset_hold)
      hw_pd_exit <= 1'b0;
      wait_lvl(1, 1'b0, 600, n);
      `CHK("pd restart", 1'b0, port_reset)
   endtask
   task automatic t_wd_period;
      logic [31:0] d;
      int n;
      bw(ADR_PERIOD, 32'h1);
      bw(ADR_IE1, 32'h1);
      br(ADR_IE1, d);
      `CHK("sw start", 32'h1, d)
      for (int p = 1; p <= 3; p += 2) begin
         bw(ADR_PERIOD, p);
         pulse(n);
         pulse(n);
         `CHK("timeout", (p + 1) * WDT, n)
         @(posedge mclk);
         #1;
         `CHK("pulse len", 1'b0, wd_reset_req)
      end
      br(ADR_IP0, d);
      `CHK("wd flag", 32'h1, d)
      br(ADR_IE1, d);
      `CHK("keeps running", 32'h1, d)
   endtask
   task automatic t_refresh;
      logic [31:0] d;
      int n;
      bw(ADR_PERIOD, 32'd20);
      pulse(n);
      repeat (30) @(posedge mclk);
      bws(3, ADR_IE0, 32'h1, ADR_PERIOD, 32'd20, ADR_IE1, 32'h1);
      br(ADR_COUNT, d);
      `CHK("broken pair", 1'b1, d < 20)
      bw(ADR_IE1, 32'h1);
      br(ADR_COUNT, d);
      `CHK("start only", 1'b1, d < 20)
      bws(2, ADR_IE0, 32'h1, ADR_IE1, 32'h1, 8'h0, 32'h0);
      br(ADR_COUNT, d);
      `CHK("refresh", 32'd20, d)
   endtask
   task automatic t_irq_flag;
      logic [31:0] d;
      int n;
      bw(ADR_PERIOD, 32'h7);
      bw(ADR_IRQ_CLR, 32'h7);
      bw(ADR_IRQ_EN, 32'h1);
      pulse(n);
      repeat (2) @(posedge mclk);
      #1;
      `CHK("irq set", 1'b1, irq)
      br(ADR_IRQ_STAT, d);
      `CHK("stat exp", 1'b1, d[IRQ_EXPIRE])
      bw(ADR_IRQ_EN, 32'h0);
      repeat (2) @(posedge mclk);
      #1;
      `CHK("irq mask", 1'b0, irq)
      bw(ADR_IRQ_EN, 32'h1);
      repeat (2) @(posedge mclk);
      #1;
      `CHK("irq unmask", 1'b1, irq)
      bw(ADR_IRQ_CLR, 32'h1);
      repeat (2) @(posedge mclk);
      #1;
      `CHK("irq clr", 1'b0, irq)
      bw(ADR_IP0, 32'h0);
      br(ADR_IP0, d);
      `CHK("flag clr", 32'h0, d)
      bw(8'h30, 32'h5);
      br(ADR_PERIOD, d);
      `CHK("unmapped wr", 32'h7, d)
   endtask
   task automatic t_strap;
      logic [31:0] d;
      do_reset(1'b1);
      br(ADR_IE1, d);
      `CHK("hw start", 32'h1, d)
   endtask
   // ****************************************
   // Sequence, watchdog and verdict
   // ****************************************
   task automatic summarize;
      if (err_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      do_reset(1'b0);
      t_reset_vals();
      t_osc();
      t_wd_period();
      t_refresh();
      t_irq_flag();
      t_strap();
      summarize();
   end
   // Whole run needs well under 20k cycles
   initial begin
      #500us;
      err_count++;
      summarize();
   end
endmodule // testbench
`default_nettype wire
